//--- hw/ldm_ctrl.sv
// Line diagnostics control bank with pattern generator
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1 - 00: normal data, or zeros with ref clock
// R2 - 01: transmit continuous all ones
// R3 - 10: PRBS 2^15-1 E1, QRSS 2^20-1 T1
// R4 - 11: repeat programmed transmit inband code
// R5 - Pattern timed by tx or master clock
// R6 - Invert bit inverts pseudo-random data
// R7 - Criterion bit selects loss/alarm rule set
// R8 - AIS on receive outputs during loss
// R9 - Auto ones during loss when select 00
// R10 - Auto remote loopback enable bit
// R11 - Remote loopback returns received data
// R12 - Analog loopback enable bit
// R13 - Digital loopback feeds transmit into receive
// R14 - Transmit code length 5 to 8, default 5
// R15 - Activate code length 5 to 8, default 5
// R16 - Deactivate code length resets to six bits
// R17 - Transmit code register, default 00001
// R18 - Activate code register, default 00001
// R19 - Deactivate code register, default 001001
// R20 - Reserved bits read zero, writes ignored
module ldm_ctrl #(
    parameter int QRSS_ZERO_RUN = 14
) (
    input wire logic CORE_CLK, // 40 MHz core clock
    input wire logic SRST, // Synchronous reset
    input wire ldm_pkg::ldm_bus_t BUS, // Register access
    input wire ldm_pkg::ldm_pins_t PINS, // Line side pins
    output logic [7:0] RD_DATA, // Read data
    output logic TX_LINE_DATA, // Transmit bit
    output logic TX_PATTERN_ACTIVE, // Pattern inserted
    output logic RX_POS_RAIL, // Receive positive rail
    output logic RX_NEG_RAIL, // Receive negative rail
    output logic RX_CLOCK, // Receive clock out
    output ldm_pkg::ldm_cfg_t CFG // Settings for detectors
);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (QRSS_ZERO_RUN < 1 || QRSS_ZERO_RUN > 31) begin : g_bad
        $error("QRSS_ZERO_RUN out of range");
    end

    localparam logic [4:0] ZERO_LIMIT = 5'(QRSS_ZERO_RUN);

    ldm_pkg::ldm_state_t s;
    ldm_pkg::ldm_state_t next_s;
    ldm_pkg::ldm_seq_t seq;
    logic tick_tx;
    logic tick_ref;
    logic tick;
    logic use_ref;
    logic los;
    logic e1;
    logic ones_on_loss;
    logic ais_on;
    logic prbs_raw;
    logic prbs_bit;
    logic code_bit;
    logic src_bit;
    logic fb;
    logic [2:0] code_last;
    logic [2:0] code_cur;

    // ----------------------------------------
    // Decoded controls
    // ----------------------------------------
    assign seq = ldm_pkg::ldm_seq_t'(s.pattern[ldm_pkg::SEQ_LSB +: 2]);
    assign use_ref = s.pattern[ldm_pkg::REF_BIT];
    assign tick_tx = s.sync2[ldm_pkg::PIN_TX_CLK] & ~s.prev[0];
    assign tick_ref = s.sync2[ldm_pkg::PIN_REF_CLK] & ~s.prev[1];
    assign tick = use_ref ? tick_ref : tick_tx; // R5
    assign los = s.sync2[ldm_pkg::PIN_LOS];
    assign e1 = s.sync2[ldm_pkg::PIN_E1];
    assign ones_on_loss = s.pattern[ldm_pkg::AUTO_ONES_ON_LOSS_BIT] & los;
    assign ais_on = s.pattern[ldm_pkg::AIS_BIT] & los;
    assign code_last = ldm_pkg::CODE_LAST_MIN + {1'b0, s.len[ldm_pkg::TX_LEN_LSB +: 2]}; // R14
    assign code_cur = (s.code_idx > code_last) ? code_last : s.code_idx;
    assign code_bit = s.tx_code[code_cur]; // R17

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.rd_data = '0;
        next_s.sync1 = PINS;
        next_s.sync2 = s.sync1;
        next_s.prev = {s.sync2[ldm_pkg::PIN_REF_CLK], s.sync2[ldm_pkg::PIN_TX_CLK]};
        fb = 1'b0;
        prbs_raw = 1'b0;
        prbs_bit = 1'b0;
        src_bit = 1'b0;

        // Register writes, reserved bits masked off
        if (BUS.wr) begin
            if (BUS.addr == ldm_pkg::OFF_PATTERN) begin
                next_s.pattern = BUS.wdata & ldm_pkg::MASK_PATTERN; // R20
            end else if (BUS.addr == ldm_pkg::OFF_LOOP) begin
                next_s.loop = BUS.wdata & ldm_pkg::MASK_LOOP; // R20
            end else if (BUS.addr == ldm_pkg::OFF_LEN) begin
                next_s.len = BUS.wdata & ldm_pkg::MASK_LEN; // R20
            end else if (BUS.addr == ldm_pkg::OFF_TX_CODE) begin
                next_s.tx_code = BUS.wdata; // R17
            end else if (BUS.addr == ldm_pkg::OFF_RX_ACT) begin
                next_s.rx_act = BUS.wdata; // R18
            end else if (BUS.addr == ldm_pkg::OFF_RX_DEACT) begin
                next_s.rx_deact = BUS.wdata; // R19
            end
        end

        // Register reads, unmapped reads zero
        if (BUS.rd) begin
            if (BUS.addr == ldm_pkg::OFF_PATTERN) begin
                next_s.rd_data = s.pattern;
            end else if (BUS.addr == ldm_pkg::OFF_LOOP) begin
                next_s.rd_data = s.loop;
            end else if (BUS.addr == ldm_pkg::OFF_LEN) begin
                next_s.rd_data = s.len;
            end else if (BUS.addr == ldm_pkg::OFF_TX_CODE) begin
                next_s.rd_data = s.tx_code;
            end else if (BUS.addr == ldm_pkg::OFF_RX_ACT) begin
                next_s.rd_data = s.rx_act;
            end else if (BUS.addr == ldm_pkg::OFF_RX_DEACT) begin
                next_s.rd_data = s.rx_deact;
            end
        end

        // Pseudo-random source, stepped on each pattern tick
        if (e1) begin
            fb = s.lfsr[ldm_pkg::E1_TAP_A] ^ s.lfsr[ldm_pkg::E1_TAP_B]; // R3
            prbs_raw = s.lfsr[ldm_pkg::E1_TAP_A];
            prbs_bit = prbs_raw;
        end else begin
            fb = s.lfsr[ldm_pkg::T1_TAP_A] ^ s.lfsr[ldm_pkg::T1_TAP_B]; // R3
            prbs_raw = s.lfsr[ldm_pkg::T1_TAP_A];
            // Zero suppression of the quasi-random signal
            prbs_bit = (s.zero_run >= ZERO_LIMIT) ? 1'b1 : prbs_raw; // R3
        end
        prbs_bit = prbs_bit ^ s.pattern[ldm_pkg::INV_BIT]; // R6

        // Remote loopback replaces the normal transmit source
        if (s.loop[ldm_pkg::RLP_BIT]) begin
            src_bit = s.sync2[ldm_pkg::PIN_RX_POS]; // R11
        end else begin
            src_bit = s.sync2[ldm_pkg::PIN_TX_DATA];
        end

        if (tick) begin
            next_s.lfsr = {s.lfsr[18:0], fb};
            // Keep the generator out of the all-zero lock state
            if ({s.lfsr[18:0], fb} == 20'h00000) begin
                next_s.lfsr = ldm_pkg::LFSR_SEED;
            end
            if (prbs_raw || s.zero_run == 5'h1f) begin
                next_s.zero_run = 5'h00;
            end else begin
                next_s.zero_run = s.zero_run + 5'h01;
            end
            next_s.code_idx = (code_cur == 3'h0) ? code_last : code_cur - 3'h1; // R4
            case (seq)
                ldm_pkg::SEQ_NORMAL: begin
                    if (ones_on_loss) begin
                        next_s.tx_data = 1'b1; // R9
                    end else if (use_ref) begin
                        next_s.tx_data = 1'b0; // R1
                    end else begin
                        next_s.tx_data = src_bit; // R1
                    end
                end
                ldm_pkg::SEQ_ONES: begin
                    next_s.tx_data = 1'b1; // R2
                end
                ldm_pkg::SEQ_PRBS: begin
                    next_s.tx_data = prbs_bit; // R3
                end
                ldm_pkg::SEQ_CODE: begin
                    next_s.tx_data = code_bit; // R4
                end
                default: begin
                    next_s.tx_data = src_bit;
                end
            endcase
            next_s.tx_active = (seq != ldm_pkg::SEQ_NORMAL) || use_ref || ones_on_loss;
        end

        // Receive side: alarm fill, digital loopback or pass-through
        if (ais_on) begin
            if (tick_ref) begin
                next_s.ais_phase = ~s.ais_phase;
            end
            next_s.rx_pos = s.ais_phase; // R8
            next_s.rx_neg = ~s.ais_phase; // R8
            next_s.rx_clk = s.sync2[ldm_pkg::PIN_REF_CLK]; // R8
        end else if (s.loop[ldm_pkg::DLP_BIT]) begin
            next_s.rx_pos = s.tx_data; // R13
            next_s.rx_neg = 1'b0;
            next_s.rx_clk = s.sync2[ldm_pkg::PIN_TX_CLK]; // R13
        end else begin
            next_s.rx_pos = s.sync2[ldm_pkg::PIN_RX_POS];
            next_s.rx_neg = s.sync2[ldm_pkg::PIN_RX_NEG];
            next_s.rx_clk = s.sync2[ldm_pkg::PIN_RX_CLK];
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            s <= '0;
            s.pattern <= ldm_pkg::RST_PATTERN;
            s.loop <= ldm_pkg::RST_LOOP;
            s.len <= ldm_pkg::RST_LEN; // R16
            s.tx_code <= ldm_pkg::RST_TX_CODE; // R17
            s.rx_act <= ldm_pkg::RST_RX_ACT; // R18
            s.rx_deact <= ldm_pkg::RST_RX_DEACT; // R19
            s.lfsr <= ldm_pkg::LFSR_SEED;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign RD_DATA = s.rd_data;
    assign TX_LINE_DATA = s.tx_data;
    assign TX_PATTERN_ACTIVE = s.tx_active;
    assign RX_POS_RAIL = s.rx_pos;
    assign RX_NEG_RAIL = s.rx_neg;
    assign RX_CLOCK = s.rx_clk;
    assign CFG.loss_alarm_criterion = s.pattern[ldm_pkg::LAC_BIT]; // R7
    assign CFG.pseudo_random_invert = s.pattern[ldm_pkg::INV_BIT]; // R6
    assign CFG.auto_remote_loop_en = s.loop[ldm_pkg::AUTO_REMOTE_LOOP_EN_BIT]; // R10
    assign CFG.remote_loop_en = s.loop[ldm_pkg::RLP_BIT]; // R11
    assign CFG.analog_loop_en = s.loop[ldm_pkg::ALP_BIT]; // R12
    assign CFG.digital_loop_en = s.loop[ldm_pkg::DLP_BIT]; // R13
    assign CFG.rx_activate_code_len = s.len[ldm_pkg::ACT_LEN_LSB +: 2]; // R15
    assign CFG.rx_deactivate_code_len = s.len[ldm_pkg::DEACT_LEN_LSB +: 2]; // R16
    assign CFG.rx_activate_code = s.rx_act; // R18
    assign CFG.rx_deactivate_code = s.rx_deact; // R19

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    reset_values_a: assert property ( // R16
        @(posedge CORE_CLK) SRST |=> (s.len == ldm_pkg::RST_LEN)
            && (s.tx_code == ldm_pkg::RST_TX_CODE) && (s.rx_deact == ldm_pkg::RST_RX_DEACT))
        else $error("Register reset values wrong");

    reserved_zero_a: assert property ( // R20
        @(posedge CORE_CLK) disable iff (SRST)
        BUS.rd && BUS.addr == ldm_pkg::OFF_LOOP |=> RD_DATA[7:4] == 4'h0
            && RD_DATA[3:0] == $past(s.loop[3:0]))
        else $error("Loop register read wrong");

    ones_insert_a: assert property ( // R2
        @(posedge CORE_CLK) disable iff (SRST)
        tick && seq == ldm_pkg::SEQ_ONES |=> TX_LINE_DATA && TX_PATTERN_ACTIVE)
        else $error("All ones not sent");

    zero_insert_a: assert property ( // R1
        @(posedge CORE_CLK) disable iff (SRST)
        tick && seq == ldm_pkg::SEQ_NORMAL && use_ref && !ones_on_loss |=> !TX_LINE_DATA)
        else $error("All zeros not sent");

    auto_ones_a: assert property ( // R9
        @(posedge CORE_CLK) disable iff (SRST)
        tick && seq == ldm_pkg::SEQ_NORMAL && ones_on_loss |=> TX_LINE_DATA)
        else $error("Ones during loss not sent");

    clock_select_a: assert property ( // R5
        @(posedge CORE_CLK) disable iff (SRST)
        use_ref && !tick_ref && !BUS.wr |=> $stable(TX_LINE_DATA))
        else $error("Pattern moved off its clock");

    prbs_invert_a: assert property ( // R6
        @(posedge CORE_CLK) disable iff (SRST)
        tick && seq == ldm_pkg::SEQ_PRBS && e1
            |=> TX_LINE_DATA == ($past(s.lfsr[ldm_pkg::E1_TAP_A])
            ^ $past(s.pattern[ldm_pkg::INV_BIT])))
        else $error("PRBS inversion wrong");

    ais_fill_a: assert property ( // R8
        @(posedge CORE_CLK) disable iff (SRST)
        ais_on |=> RX_CLOCK == $past(s.sync2[ldm_pkg::PIN_REF_CLK])
            && RX_POS_RAIL != RX_NEG_RAIL)
        else $error("AIS fill missing");

    digital_loop_a: assert property ( // R13
        @(posedge CORE_CLK) disable iff (SRST)
        s.loop[ldm_pkg::DLP_BIT] && !ais_on
            |=> RX_POS_RAIL == $past(s.tx_data) && !RX_NEG_RAIL)
        else $error("Digital loopback wrong");

    // ----------------------------------------
    // Checks of transmit source, receive path and registers
    // ----------------------------------------
    qrss_output_a: assert property ( // R3
        @(posedge CORE_CLK) disable iff (SRST)
        tick && seq == ldm_pkg::SEQ_PRBS && !e1
            |=> TX_LINE_DATA == (($past(s.lfsr[ldm_pkg::T1_TAP_A])
            || ($past(s.zero_run) >= ZERO_LIMIT)) ^ $past(s.pattern[ldm_pkg::INV_BIT])))
        else $error("Quasi-random output wrong");

    lfsr_live_a: assert property ( // R3
        @(posedge CORE_CLK) disable iff (SRST)
        s.lfsr != '0)
        else $error("Generator stuck at zero");

    code_insert_a: assert property ( // R4
        @(posedge CORE_CLK) disable iff (SRST)
        tick && seq == ldm_pkg::SEQ_CODE |=> TX_LINE_DATA == $past(s.tx_code[code_cur]))
        else $error("Inband code bit wrong");

    code_index_a: assert property ( // R14
        @(posedge CORE_CLK) disable iff (SRST)
        tick |=> s.code_idx <= $past(code_last))
        else $error("Code index beyond length");

    remote_loop_a: assert property ( // R11
        @(posedge CORE_CLK) disable iff (SRST)
        tick && seq == ldm_pkg::SEQ_NORMAL && !use_ref && !ones_on_loss
            && s.loop[ldm_pkg::RLP_BIT]
            |=> TX_LINE_DATA == $past(s.sync2[ldm_pkg::PIN_RX_POS]))
        else $error("Remote loopback data wrong");

    rx_pass_a: assert property ( // R8
        @(posedge CORE_CLK) disable iff (SRST)
        !ais_on && !s.loop[ldm_pkg::DLP_BIT]
            |=> RX_POS_RAIL == $past(s.sync2[ldm_pkg::PIN_RX_POS])
            && RX_NEG_RAIL == $past(s.sync2[ldm_pkg::PIN_RX_NEG])
            && RX_CLOCK == $past(s.sync2[ldm_pkg::PIN_RX_CLK]))
        else $error("Receive pass-through wrong");

    reserved_bits_a: assert property ( // R20
        @(posedge CORE_CLK) disable iff (SRST)
        (s.pattern & ~ldm_pkg::MASK_PATTERN) == 8'h00
            && (s.loop & ~ldm_pkg::MASK_LOOP) == 8'h00
            && (s.len & ~ldm_pkg::MASK_LEN) == 8'h00)
        else $error("Reserved bit stored");

    idle_read_a: assert property ( // R20
        @(posedge CORE_CLK) disable iff (SRST)
        !BUS.rd |=> RD_DATA == 8'h00)
        else $error("Read data without read");

endmodule : ldm_ctrl
`default_nettype wire

//--- pkg/ldm_pkg.sv
// Constants and types of the line diagnostics control bank
`default_nettype none
package ldm_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] OFF_PATTERN = 8'h0d;
    localparam logic [7:0] OFF_LOOP = 8'h0e;
    localparam logic [7:0] OFF_LEN = 8'h0f;
    localparam logic [7:0] OFF_TX_CODE = 8'h10;
    localparam logic [7:0] OFF_RX_ACT = 8'h11;
    localparam logic [7:0] OFF_RX_DEACT = 8'h12;
    localparam logic [7:0] RST_PATTERN = 8'h00;
    localparam logic [7:0] RST_LOOP = 8'h00;
    localparam logic [7:0] RST_LEN = 8'h01;
    localparam logic [7:0] RST_TX_CODE = 8'h01;
    localparam logic [7:0] RST_RX_ACT = 8'h01;
    localparam logic [7:0] RST_RX_DEACT = 8'h09;
    localparam logic [7:0] MASK_PATTERN = 8'h7f;
    localparam logic [7:0] MASK_LOOP = 8'h0f;
    localparam logic [7:0] MASK_LEN = 8'h3f;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int SEQ_LSB = 5;
    localparam int REF_BIT = 4;
    localparam int INV_BIT = 3;
    localparam int LAC_BIT = 2;
    localparam int AIS_BIT = 1;
    localparam int AUTO_ONES_ON_LOSS_BIT = 0;
    localparam int AUTO_REMOTE_LOOP_EN_BIT = 3;
    localparam int RLP_BIT = 2;
    localparam int ALP_BIT = 1;
    localparam int DLP_BIT = 0;
    localparam int TX_LEN_LSB = 4;
    localparam int ACT_LEN_LSB = 2;
    localparam int DEACT_LEN_LSB = 0;
    localparam logic [2:0] CODE_LAST_MIN = 3'h4;
    // ----------------------------------------
    // Pseudo-random generators
    // ----------------------------------------
    localparam int E1_TAP_A = 14;
    localparam int E1_TAP_B = 13;
    localparam int T1_TAP_A = 19;
    localparam int T1_TAP_B = 16;
    localparam logic [19:0] LFSR_SEED = 20'h00001;
    // ----------------------------------------
    // Pin positions in the synchroniser
    // ----------------------------------------
    localparam int PIN_TX_CLK = 0;
    localparam int PIN_REF_CLK = 1;
    localparam int PIN_TX_DATA = 2;
    localparam int PIN_LOS = 3;
    localparam int PIN_RX_POS = 4;
    localparam int PIN_RX_NEG = 5;
    localparam int PIN_RX_CLK = 6;
    localparam int PIN_E1 = 7;

    typedef enum logic [1:0] {SEQ_NORMAL, SEQ_ONES, SEQ_PRBS, SEQ_CODE} ldm_seq_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ldm_bus_t;

    typedef struct packed {
        logic e1_mode;
        logic rx_clock;
        logic rx_neg_rail;
        logic rx_pos_rail;
        logic los;
        logic tx_data;
        logic master_ref_clock;
        logic tx_line_clock;
    } ldm_pins_t;

    typedef struct packed {
        logic loss_alarm_criterion;
        logic pseudo_random_invert;
        logic auto_remote_loop_en;
        logic remote_loop_en;
        logic analog_loop_en;
        logic digital_loop_en;
        logic [1:0] rx_activate_code_len;
        logic [1:0] rx_deactivate_code_len;
        logic [7:0] rx_activate_code;
        logic [7:0] rx_deactivate_code;
    } ldm_cfg_t;

    typedef struct packed {
        logic [7:0] pattern;
        logic [7:0] loop;
        logic [7:0] len;
        logic [7:0] tx_code;
        logic [7:0] rx_act;
        logic [7:0] rx_deact;
        logic [7:0] rd_data;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [1:0] prev;
        logic [19:0] lfsr;
        logic [4:0] zero_run;
        logic [2:0] code_idx;
        logic tx_data;
        logic tx_active;
        logic rx_pos;
        logic rx_neg;
        logic rx_clk;
        logic ais_phase;
    } ldm_state_t;
endpackage : ldm_pkg
`default_nettype wire

//--- testbench/test_ldm_ctrl.sv
// Self-checking testbench of the line diagnostics control bank
`timescale 1ns/10ps
`default_nettype none
module test_ldm_ctrl;
    // ----------------------------------------
    // Signals and instance
    // ----------------------------------------
    logic CORE_CLK = 1'b0;
    logic SRST = 1'b1;
    ldm_pkg::ldm_bus_t bus = '0;
    ldm_pkg::ldm_pins_t pins = '0;
    logic [7:0] rd_data;
    logic tx_bit, tx_act, rx_pos, rx_neg, rx_clk;
    ldm_pkg::ldm_cfg_t cfg;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] offs [6] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12};
    logic [7:0] rsts [6] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h09};
    logic [7:0] masks [6] = '{8'h7f, 8'h0f, 8'h3f, 8'hff, 8'hff, 8'hff};
    logic bits [0:23];
    logic prev;
    int len, ones;
    logic found, ok;

    ldm_ctrl i_ldm_ctrl (
        .CORE_CLK(CORE_CLK),
        .SRST(SRST),
        .BUS(bus),
        .PINS(pins),
        .RD_DATA(rd_data),
        .TX_LINE_DATA(tx_bit),
        .TX_PATTERN_ACTIVE(tx_act),
        .RX_POS_RAIL(rx_pos),
        .RX_NEG_RAIL(rx_neg),
        .RX_CLOCK(rx_clk),
        .CFG(cfg)
    );

    initial begin
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("checked %0d, bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge CORE_CLK);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge CORE_CLK);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge CORE_CLK);
        bus.rd <= 1'b0;
        #1 chk(rd_data, exp);
    endtask : rd_chk

    // One pattern clock period on the chosen pin clock
    task automatic tick(input logic use_ref);
        @(posedge CORE_CLK);
        if (use_ref) pins.master_ref_clock <= 1'b1;
        else pins.tx_line_clock <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        if (use_ref) pins.master_ref_clock <= 1'b0;
        else pins.tx_line_clock <= 1'b0;
        repeat (4) @(posedge CORE_CLK);
        #1;
    endtask : tick

    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge CORE_CLK);
        SRST <= 1'b0;
        #1 chk({6'h0, cfg.rx_deactivate_code_len}, 8'h01);
        chk(cfg.rx_activate_code, 8'h01);
        chk(cfg.rx_deactivate_code, 8'h09);
        for (int i = 0; i < 6; i++) rd_chk(offs[i], rsts[i]);
        @(posedge CORE_CLK);
        #1 chk(rd_data, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(offs[i], 8'hff);
            rd_chk(offs[i], masks[i]);
        end
        chk({2'h0, cfg[25:20]}, 8'h3f);
        chk({4'h0, cfg.rx_activate_code_len, cfg.rx_deactivate_code_len}, 8'h0f);
        chk(cfg.rx_activate_code, 8'hff);
        chk(cfg.rx_deactivate_code, 8'hff);
        wr(8'h13, 8'h00);
        rd_chk(8'h13, 8'h00);
        rd_chk(8'h0c, 8'h00);
        rd_chk(8'h12, 8'hff);
        for (int i = 0; i < 4; i++) begin
            wr(8'h0e, 8'h01 << i);
            #1 chk({4'h0, cfg[23:20]}, 8'h01 << i);
        end
        wr(8'h0e, 8'h00);
        wr(8'h0d, 8'h08);
        #1 chk({6'h0, cfg[25:24]}, 8'h01);
        wr(8'h0d, 8'h04);
        #1 chk({6'h0, cfg[25:24]}, 8'h02);
        // All ones, then zeros timed only by the master clock
        wr(8'h0d, 8'h20);
        tick(1'b0);
        tick(1'b0);
        chk({6'h0, tx_act, tx_bit}, 8'h03);
        pins.tx_data <= 1'b1;
        wr(8'h0d, 8'h10);
        tick(1'b0);
        tick(1'b0);
        chk({7'h0, tx_bit}, 8'h01);
        tick(1'b1);
        tick(1'b1);
        chk({6'h0, tx_act, tx_bit}, 8'h02);
        wr(8'h0d, 8'h00);
        tick(1'b0);
        tick(1'b0);
        chk({6'h0, tx_act, tx_bit}, 8'h01);
        // Auto ones during loss
        pins.tx_data <= 1'b0;
        pins.los <= 1'b1;
        wr(8'h0d, 8'h01);
        tick(1'b0);
        tick(1'b0);
        chk({6'h0, tx_act, tx_bit}, 8'h03);
        // Alarm fill on receive outputs
        pins.rx_pos_rail <= 1'b1;
        pins.rx_neg_rail <= 1'b1;
        pins.rx_clock <= 1'b1;
        wr(8'h0d, 8'h02);
        tick(1'b1);
        tick(1'b1);
        chk({6'h0, rx_clk, rx_pos ^ rx_neg}, 8'h01);
        prev = rx_pos;
        tick(1'b1);
        chk({7'h0, rx_pos}, {7'h0, ~prev});
        // Receive clock follows the master clock during fill
        @(posedge CORE_CLK);
        pins.master_ref_clock <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        #1 chk({7'h0, rx_clk}, 8'h01);
        @(posedge CORE_CLK);
        pins.master_ref_clock <= 1'b0;
        wr(8'h0d, 8'h00);
        repeat (5) @(posedge CORE_CLK);
        #1 chk({5'h0, rx_clk, rx_pos, rx_neg}, 8'h07);
        pins.los <= 1'b0;
        // Digital and remote loopback
        pins.tx_data <= 1'b1;
        wr(8'h0e, 8'h01);
        tick(1'b0);
        tick(1'b0);
        chk({5'h0, rx_clk, rx_pos, rx_neg}, 8'h02);
        wr(8'h0e, 8'h04);
        pins.tx_data <= 1'b0;
        tick(1'b0);
        tick(1'b0);
        chk({7'h0, tx_bit}, 8'h01);
        wr(8'h0e, 8'h00);
        tick(1'b0);
        tick(1'b0);
        chk({7'h0, tx_bit}, 8'h00);
        // Inband code for every length, matched against any phase
        wr(8'h10, 8'hb5);
        wr(8'h0d, 8'h60);
        for (int l = 0; l < 4; l++) begin
            len = 5 + l;
            wr(8'h0f, 8'(l << 4) | 8'h01);
            for (int i = 0; i < 3 * len; i++) begin
                tick(1'b0);
                bits[i] = tx_bit;
            end
            found = 1'b0;
            for (int k = 0; k < len; k++) begin
                ok = 1'b1;
                for (int i = len; i < 3 * len; i++) begin
                    if (bits[i] !== 1'(8'hb5 >> (len - 1 - ((i + k) % len)))) ok = 1'b0;
                end
                if (ok) found = 1'b1;
            end
            chk({6'h0, tx_act, found}, 8'h03);
        end
        // Pseudo-random output in both line modes
        for (int m = 0; m < 2; m++) begin
            pins.e1_mode <= m[0];
            wr(8'h0d, 8'h40 | 8'(m << 3));
            ones = 0;
            for (int i = 0; i < 30; i++) begin
                tick(1'b0);
                if (tx_bit === 1'b1) ones++;
            end
            chk({7'h0, ones > 3 && ones < 27}, 8'h01);
        end
        give_verdict();
    end
endmodule : test_ldm_ctrl
`default_nettype wire
